/* rtl/io_block.sv */
// Pin block: control selection, clock edges and routing for four cells.
`timescale 1ns/1ps
module io_block
    import io_cell_pkg::*;
(
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    input  wire logic [GLB_CLKS-1:0]         global_clk,
    input  wire logic [GLB_CLKS-1:0]         regional_clk,
    input  wire logic [IOE_CLKS-1:0][2:0]    cfg_ioe_src,
    input  wire logic [CELLS-1:0]            dataout_a,
    input  wire logic [CELLS-1:0]            dataout_b,
    input  wire logic [CELLS-1:0]            blk_oe,
    input  wire logic [CELLS-1:0]            blk_ce_in,
    input  wire logic [CELLS-1:0]            blk_ce_out,
    input  wire logic [CELLS-1:0]            blk_clk,
    input  wire logic [CELLS-1:0]            blk_aclr,
    input  wire logic [CELLS-1:0]            blk_sclr,
    input  wire logic                        cfg_row_block,
    input  wire logic [CELLS-1:0][1:0]       cfg_route,
    input  wire logic [CELLS-1:0][3:0]       cfg_sel_oe,
    input  wire logic [CELLS-1:0][3:0]       cfg_sel_ce_in,
    input  wire logic [CELLS-1:0][3:0]       cfg_sel_ce_out,
    input  wire logic [CELLS-1:0][3:0]       cfg_sel_aclr,
    input  wire logic [CELLS-1:0][3:0]       cfg_sel_sclr,
    input  wire logic [CELLS-1:0][3:0]       cfg_sel_clk_in,
    input  wire logic [CELLS-1:0][3:0]       cfg_sel_clk_out,
    input  wire logic [CELLS-1:0][INV_W-1:0] cfg_invert,
    input  wire logic [CELLS-1:0]            cfg_powerup_high,
    input  wire logic [CELLS-1:0]            cfg_ddr_in,
    input  wire logic [CELLS-1:0]            cfg_ddr_out,
    input  wire logic [CELLS-1:0]            cfg_oe_negedge,
    input  wire logic [CELLS-1:0]            pin_in,
    output logic      [CELLS-1:0]            pin_out,
    output logic      [CELLS-1:0]            pin_oe_n,
    output logic      [CELLS-1:0]            col_data_a,
    output logic      [CELLS-1:0]            col_data_b,
    output logic      [CELLS-1:0]            row_data_a,
    output logic      [CELLS-1:0]            row_data_b,
    output logic      [CELLS-1:0]            link_data_a,
    output logic      [CELLS-1:0]            link_data_b
);

    block_s st;
    block_s next_st;

    logic [IOE_CLKS-1:0] ioe_clk;
    logic [CELLS-1:0]    sig_oe;
    logic [CELLS-1:0]    sig_ce_in;
    logic [CELLS-1:0]    sig_ce_out;
    logic [CELLS-1:0]    sig_aclr;
    logic [CELLS-1:0]    sig_sclr;
    logic [CELLS-1:0]    sig_clk_in;
    logic [CELLS-1:0]    sig_clk_out;
    logic [CELLS-1:0]    sig_data_a;
    logic [CELLS-1:0]    sig_data_b;
    logic [CELLS-1:0]    sig_pin;
    logic [CELLS-1:0]    in_rise;
    logic [CELLS-1:0]    in_fall;
    logic [CELLS-1:0]    out_rise;
    logic [CELLS-1:0]    out_fall;
    logic [CELLS-1:0]    cap_a;
    logic [CELLS-1:0]    cap_b;

    // Selector shared by every control input of a cell. Codes 0 to 3 take
    // a block line, the next eight take a dedicated clock through the local
    // routing, and two fixed codes give constant levels. Spare codes read
    // as zero so a stray setting never enables anything.
    function automatic logic pick(
        input logic [3:0]          sel,
        input logic [CELLS-1:0]    blk,
        input logic [IOE_CLKS-1:0] ioe
    );
        logic [3:0] idx;
        idx = sel - SEL_IOE_BASE;
        if (sel < SEL_IOE_BASE) begin
            pick = blk[sel[1:0]];
        end else if (sel == SEL_ONE) begin
            pick = 1'b1;
        end else if (sel == SEL_ZERO) begin
            pick = 1'b0;
        end else if (idx < 4'(IOE_CLKS)) begin
            pick = ioe[idx[2:0]];
        end else begin
            pick = 1'b0;
        end
    endfunction : pick

    // Each dedicated clock line is drawn from a global or regional clock;
    // the top bit of the source code chooses the regional set.
    always_comb begin
        for (int i = 0; i < IOE_CLKS; i++) begin
            if (cfg_ioe_src[i][2]) begin
                ioe_clk[i] = regional_clk[cfg_ioe_src[i][1:0]];
            end else begin
                ioe_clk[i] = global_clk[cfg_ioe_src[i][1:0]];
            end
        end
    end

    // Per-cell control selection and inversion. All 32 lines from the
    // logic array enter here; each cell picks its own sources.
    always_comb begin
        for (int c = 0; c < CELLS; c++) begin
            sig_oe[c]      = pick(cfg_sel_oe[c], blk_oe, ioe_clk)
                             ^ cfg_invert[c][INV_OE];
            sig_ce_in[c]   = pick(cfg_sel_ce_in[c], blk_ce_in, ioe_clk)
                             ^ cfg_invert[c][INV_CE_IN];
            sig_ce_out[c]  = pick(cfg_sel_ce_out[c], blk_ce_out, ioe_clk)
                             ^ cfg_invert[c][INV_CE_OUT];
            sig_aclr[c]    = pick(cfg_sel_aclr[c], blk_aclr, ioe_clk)
                             ^ cfg_invert[c][INV_ACLR];
            sig_sclr[c]    = pick(cfg_sel_sclr[c], blk_sclr, ioe_clk)
                             ^ cfg_invert[c][INV_SCLR];
            sig_clk_in[c]  = pick(cfg_sel_clk_in[c], blk_clk, ioe_clk)
                             ^ cfg_invert[c][INV_CLK_IN];
            sig_clk_out[c] = pick(cfg_sel_clk_out[c], blk_clk, ioe_clk)
                             ^ cfg_invert[c][INV_CLK_OUT];
            sig_data_a[c]  = dataout_a[c] ^ cfg_invert[c][INV_DATA_A];
            sig_data_b[c]  = dataout_b[c] ^ cfg_invert[c][INV_DATA_B];
            sig_pin[c]     = pin_in[c] ^ cfg_invert[c][INV_PIN];
        end
    end

    // The cell clocks are sampled levels on the system clock, so their
    // edges become one-cycle enables. A cell clock must therefore run well
    // below half the system rate; faster clocks lose edges.
    always_comb begin
        in_rise  = sig_clk_in & ~st.in_prev;
        in_fall  = ~sig_clk_in & st.in_prev;
        out_rise = sig_clk_out & ~st.out_prev;
        out_fall = ~sig_clk_out & st.out_prev;
    end

    // Routing of captured data. A row block drives at most one of row,
    // column or direct routing per cell, none for code 2; a column block only column.
    always_comb begin
        logic col_en;
        logic row_en;
        logic link_en;
        col_en  = 1'b0;
        row_en  = 1'b0;
        link_en = 1'b0;
        next_st = st;
        next_st.in_prev  = sig_clk_in;
        next_st.out_prev = sig_clk_out;
        for (int c = 0; c < CELLS; c++) begin
            col_en  = !cfg_row_block
                      || (cfg_route[c] == ROUTE_COL);
            row_en  = cfg_row_block && (cfg_route[c] == ROUTE_ROW);
            link_en = cfg_row_block && (cfg_route[c] == ROUTE_LINK);
            next_st.col_a[c]  = col_en & cap_a[c];
            next_st.col_b[c]  = col_en & cap_b[c];
            next_st.row_a[c]  = row_en & cap_a[c];
            next_st.row_b[c]  = row_en & cap_b[c];
            next_st.link_a[c] = link_en & cap_a[c];
            next_st.link_b[c] = link_en & cap_b[c];
        end
    end

    // Block state register; the cells carry their own clear inputs.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= BLOCK_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Four identical cells; each gets a single asynchronous clear line that every one
    // of its registers uses, which keeps clear and preset consistent.
    for (genvar g = 0; g < CELLS; g++) begin : g_cell
        io_cell u_cell (
            .clk_sys      (clk_sys),
            .reset_n      (reset_n),
            .aclr         (sig_aclr[g]),
            .sclr         (sig_sclr[g]),
            .powerup_high (cfg_powerup_high[g]),
            .ddr_in       (cfg_ddr_in[g]),
            .ddr_out      (cfg_ddr_out[g]),
            .oe_negedge   (cfg_oe_negedge[g]),
            .in_rise      (in_rise[g]),
            .in_fall      (in_fall[g]),
            .in_high      (sig_clk_in[g]),
            .ce_in        (sig_ce_in[g]),
            .out_rise     (out_rise[g]),
            .out_fall     (out_fall[g]),
            .out_high     (sig_clk_out[g]),
            .ce_out       (sig_ce_out[g]),
            .pin_in       (sig_pin[g]),
            .data_a       (sig_data_a[g]),
            .data_b       (sig_data_b[g]),
            .oe_req       (sig_oe[g]),
            .cap_a        (cap_a[g]),
            .cap_b        (cap_b[g]),
            .pin_out      (pin_out[g]),
            .pin_oe_n     (pin_oe_n[g])
        );
    end

    // Routed data leaves straight from the block state register.
    assign col_data_a  = st.col_a;
    assign col_data_b  = st.col_b;
    assign row_data_a  = st.row_a;
    assign row_data_b  = st.row_b;
    assign link_data_a = st.link_a;
    assign link_data_b = st.link_b;

endmodule : io_block

/* shared/io_cell_pkg.sv */
// Shared constants and state types for the pin block and its register cells.
package io_cell_pkg;

    // Cells per pin block and width of the dedicated clock set.
    localparam int CELLS    = 4;
    localparam int IOE_CLKS = 8;
    localparam int GLB_CLKS = 4;

    // Control source select codes: 0..3 pick a block line.
    localparam logic [3:0] SEL_IOE_BASE = 4'h4;
    localparam logic [3:0] SEL_ZERO     = 4'he;
    localparam logic [3:0] SEL_ONE      = 4'hf;

    // Bit positions of the per-cell inversion mask.
    localparam int INV_OE      = 0;
    localparam int INV_CE_IN   = 1;
    localparam int INV_CE_OUT  = 2;
    localparam int INV_ACLR    = 3;
    localparam int INV_SCLR    = 4;
    localparam int INV_CLK_IN  = 5;
    localparam int INV_CLK_OUT = 6;
    localparam int INV_DATA_A  = 7;
    localparam int INV_DATA_B  = 8;
    localparam int INV_PIN     = 9;
    localparam int INV_W       = 10;

    // Destination routing of captured input data.
    typedef enum logic [1:0] {
        ROUTE_COL  = 2'h0,
        ROUTE_ROW  = 2'h1,
        ROUTE_LINK = 2'h3
    } route_e;

    // Register state of one cell; the first seven hold value xor power-up level.
    typedef struct packed {
        logic in_a;
        logic in_b;
        logic latch;
        logic out_a;
        logic out_b;
        logic oe_a;
        logic oe_b;
        logic cap_a;
        logic cap_b;
        logic pin_q;
        logic drive_q;
    } cell_s;

    // Block state: sampled clock levels and routed data.
    typedef struct packed {
        logic [CELLS-1:0] in_prev;
        logic [CELLS-1:0] out_prev;
        logic [CELLS-1:0] col_a;
        logic [CELLS-1:0] col_b;
        logic [CELLS-1:0] row_a;
        logic [CELLS-1:0] row_b;
        logic [CELLS-1:0] link_a;
        logic [CELLS-1:0] link_b;
    } block_s;

    localparam cell_s  CELL_RESET  = '0;
    localparam block_s BLOCK_RESET = '0;

endpackage : io_cell_pkg

/* rtl/io_cell.sv */
// Register cell of one pin: input, output and output-enable registers.
`timescale 1ns/1ps
module io_cell
    import io_cell_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic aclr,
    input  wire logic sclr,
    input  wire logic powerup_high,
    input  wire logic ddr_in,
    input  wire logic ddr_out,
    input  wire logic oe_negedge,
    input  wire logic in_rise,
    input  wire logic in_fall,
    input  wire logic in_high,
    input  wire logic ce_in,
    input  wire logic out_rise,
    input  wire logic out_fall,
    input  wire logic out_high,
    input  wire logic ce_out,
    input  wire logic pin_in,
    input  wire logic data_a,
    input  wire logic data_b,
    input  wire logic oe_req,
    output logic      cap_a,
    output logic      cap_b,
    output logic      pin_out,
    output logic      pin_oe_n
);

    cell_s st;
    cell_s next_st;

    // The first seven registers hold value xor power-up level, so clearing them to zero always
    // lands on the configured clear or preset level with a constant reset; pin_q and drive_q clear to zero.
    always_comb begin
        logic a_e;
        logic b_e;
        logic oa_e;
        logic ob_e;
        logic la_e;
        logic oe_eff;
        next_st = st;
        a_e    = st.in_a ^ powerup_high;
        la_e   = st.latch ^ powerup_high;
        oa_e   = st.out_a ^ powerup_high;
        ob_e   = st.out_b ^ powerup_high;
        b_e    = st.oe_b ^ powerup_high;
        oe_eff = st.oe_a ^ powerup_high;
        // Input path has its own clock and enable.
        if (in_rise && ce_in) begin
            next_st.in_a = sclr ? 1'b0 : (pin_in ^ powerup_high);
        end
        if (in_fall && ce_in && ddr_in) begin
            next_st.in_b = sclr ? 1'b0 : (pin_in ^ powerup_high);
        end
        // Latch follows the falling-edge bit while the clock is low and
        // holds it through the high time, aligning both bits.
        if (!in_high) begin
            next_st.latch = st.in_b;
        end
        next_st.cap_a = a_e;
        next_st.cap_b = ddr_in ? la_e : a_e;
        // Output and enable registers share one clock and one enable.
        if (out_rise && ce_out) begin
            next_st.out_a = sclr ? 1'b0 : (data_a ^ powerup_high);
            next_st.out_b = sclr ? 1'b0 : (data_b ^ powerup_high);
            next_st.oe_a  = sclr ? 1'b0 : (oe_req ^ powerup_high);
        end
        // Second enable register retimes onto the falling edge.
        if (out_fall && ce_out) begin
            next_st.oe_b = sclr ? 1'b0 : st.oe_a;
        end
        // Turn-on waits for the falling edge when retiming is selected.
        if (oe_negedge) begin
            oe_eff = oe_eff & b_e;
        end
        next_st.pin_q   = (ddr_out && !out_high) ? ob_e : oa_e;
        next_st.drive_q = oe_eff;
    end

    // One shared clear source acts at once on every register of the cell.
    always_ff @(posedge clk_sys or negedge reset_n or posedge aclr) begin
        if (!reset_n) begin
            st <= CELL_RESET;
        end else if (aclr) begin
            st <= CELL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign cap_a    = st.cap_a;
    assign cap_b    = st.cap_b;
    assign pin_out  = st.pin_q;
    assign pin_oe_n = ~st.drive_q;

endmodule : io_cell

/* dv/io_block_asserts.sv */
// Concurrent checks on the pin block ports, bound to the block's top.
`timescale 1ns/1ps
module io_block_asserts
    import io_cell_pkg::*;
(
    input wire logic                        clk_sys,
    input wire logic                        reset_n,
    input wire logic [CELLS-1:0]            dataout_a,
    input wire logic [CELLS-1:0]            dataout_b,
    input wire logic [CELLS-1:0]            blk_oe,
    input wire logic [CELLS-1:0]            blk_clk,
    input wire logic                        cfg_row_block,
    input wire logic [CELLS-1:0][3:0]       cfg_sel_oe,
    input wire logic [CELLS-1:0][3:0]       cfg_sel_ce_out,
    input wire logic [CELLS-1:0][3:0]       cfg_sel_aclr,
    input wire logic [CELLS-1:0][3:0]       cfg_sel_sclr,
    input wire logic [CELLS-1:0][3:0]       cfg_sel_clk_out,
    input wire logic [CELLS-1:0][INV_W-1:0] cfg_invert,
    input wire logic [CELLS-1:0]            cfg_ddr_out,
    input wire logic [CELLS-1:0]            cfg_oe_negedge,
    input wire logic [CELLS-1:0]            pin_out,
    input wire logic [CELLS-1:0]            pin_oe_n,
    input wire logic [CELLS-1:0]            row_data_a,
    input wire logic [CELLS-1:0]            row_data_b,
    input wire logic [CELLS-1:0]            link_data_a,
    input wire logic [CELLS-1:0]            link_data_b
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Cell 0 in its plain form, so that latencies can be stated exactly.
    logic plain0;
    assign plain0 = cfg_sel_clk_out[0] == 4'h0
        && cfg_sel_ce_out[0] == SEL_ONE && cfg_sel_aclr[0] == SEL_ZERO
        && cfg_sel_sclr[0] == SEL_ZERO && cfg_invert[0] == '0;

    a_release_idle: assert property (
        $rose(reset_n) |-> pin_oe_n == 4'hf && pin_out == 4'h0)
        else $error("pin not idle right after reset");
    a_col_only: assert property (
        (!cfg_row_block) [*4] |-> row_data_a == '0 && row_data_b == '0
            && link_data_a == '0 && link_data_b == '0)
        else $error("column block drove row or link routing");
    a_aclr_idle: assert property (
        cfg_sel_aclr[0] == SEL_ONE && !cfg_invert[0][INV_ACLR]
            |-> !pin_out[0] && pin_oe_n[0])
        else $error("held clear did not force the pin idle");
    a_sdr_out: assert property (
        $rose(blk_clk[0]) && plain0 && !cfg_ddr_out[0]
            |-> ##2 pin_out[0] == $past(dataout_a[0], 2))
        else $error("output register did not carry taken data");
    a_oe_follow: assert property (
        $rose(blk_clk[0]) && plain0 && cfg_sel_oe[0] == 4'h0
            && !cfg_oe_negedge[0]
            |-> ##2 pin_oe_n[0] == !$past(blk_oe[0], 2))
        else $error("pin enable does not follow the taken enable");
    a_ce_hold: assert property (
        (cfg_sel_ce_out[0] == SEL_ZERO && cfg_sel_aclr[0] == SEL_ZERO
            && !cfg_ddr_out[0]) [*3] |-> $stable(pin_out[0]))
        else $error("pin changed with its clock enable off");
    a_ddr_phase: assert property (
        $rose(blk_clk[0]) && plain0 && cfg_ddr_out[0] ##1 blk_clk[0]
            ##1 !blk_clk[0] |-> pin_out[0] == $past(dataout_a[0], 2)
            ##1 pin_out[0] == $past(dataout_b[0], 3))
        else $error("double rate pin phases are wrong");
    a_negedge_oe: assert property (
        $fell(pin_oe_n[0]) && plain0 && cfg_oe_negedge[0]
            && $past(cfg_oe_negedge[0], 2) |-> !$past(blk_clk[0], 2))
        else $error("enable turned on before the falling edge");
endmodule : io_block_asserts

bind io_block io_block_asserts i_io_block_asserts (.clk_sys, .reset_n,
    .dataout_a, .dataout_b, .blk_oe, .blk_clk, .cfg_row_block, .cfg_sel_oe,
    .cfg_sel_ce_out, .cfg_sel_aclr, .cfg_sel_sclr, .cfg_sel_clk_out,
    .cfg_invert, .cfg_ddr_out, .cfg_oe_negedge, .pin_out, .pin_oe_n,
    .row_data_a, .row_data_b, .link_data_a, .link_data_b);

/* dv/pin_partner.sv */
// External device on the four pins, resolving each shared pin wire.
`timescale 1ns/1ps
module pin_partner
    import io_cell_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic [CELLS-1:0] pin_out,
    input  wire logic [CELLS-1:0] pin_oe_n,
    input  wire logic [CELLS-1:0] ext_drive,
    input  wire logic [CELLS-1:0] ext_level,
    output logic      [CELLS-1:0] pin_in
);
    // An undriven pin wanders, so stale data can never pass for a capture.
    logic [CELLS-1:0] float_q = '0;
    always_ff @(posedge clk_sys) begin
        float_q <= ~float_q;
    end

    // The block wins the wire while its active-low enable is low.
    always_comb begin
        for (int i = 0; i < CELLS; i++) begin
            pin_in[i] = !pin_oe_n[i] ? pin_out[i]
                : ext_drive[i] ? ext_level[i] : float_q[i];
        end
    end
endmodule : pin_partner

/* dv/io_block_test.sv */
// Self-checking bench for the pin block and its register cells.
`timescale 1ns/1ps
module io_block_test
    import io_cell_pkg::*;
;
    logic                        clk_sys = 1'b0;
    logic                        reset_n;
    logic [GLB_CLKS-1:0]         global_clk, regional_clk;
    logic [IOE_CLKS-1:0][2:0]    cfg_ioe_src;
    logic [CELLS-1:0]            dataout_a, dataout_b, blk_oe, blk_ce_in;
    logic [CELLS-1:0]            blk_ce_out, blk_clk, blk_aclr, blk_sclr;
    logic                        cfg_row_block;
    logic [CELLS-1:0][1:0]       cfg_route;
    logic [CELLS-1:0][3:0]       cfg_sel_oe, cfg_sel_ce_in, cfg_sel_ce_out;
    logic [CELLS-1:0][3:0]       cfg_sel_aclr, cfg_sel_sclr;
    logic [CELLS-1:0][3:0]       cfg_sel_clk_in, cfg_sel_clk_out;
    logic [CELLS-1:0][INV_W-1:0] cfg_invert;
    logic [CELLS-1:0]            cfg_powerup_high, cfg_ddr_in, cfg_ddr_out;
    logic [CELLS-1:0]            cfg_oe_negedge, ext_drive, ext_level;
    logic [CELLS-1:0]            pin_in, pin_out, pin_oe_n;
    logic [CELLS-1:0]            col_data_a, col_data_b, row_data_a;
    logic [CELLS-1:0]            row_data_b, link_data_a, link_data_b;
    int                          failures = 0;
    int                          tests_run = 0;

    // The logic array side: all 32 block lines come from the bench.
    io_block i_io_block (.clk_sys, .reset_n, .global_clk, .regional_clk,
        .cfg_ioe_src, .dataout_a, .dataout_b, .blk_oe, .blk_ce_in,
        .blk_ce_out, .blk_clk, .blk_aclr, .blk_sclr, .cfg_row_block,
        .cfg_route, .cfg_sel_oe, .cfg_sel_ce_in, .cfg_sel_ce_out,
        .cfg_sel_aclr, .cfg_sel_sclr, .cfg_sel_clk_in, .cfg_sel_clk_out,
        .cfg_invert, .cfg_powerup_high, .cfg_ddr_in, .cfg_ddr_out,
        .cfg_oe_negedge, .pin_in, .pin_out, .pin_oe_n, .col_data_a,
        .col_data_b, .row_data_a, .row_data_b, .link_data_a, .link_data_b);
    pin_partner i_pin_partner (.clk_sys, .pin_out, .pin_oe_n, .ext_drive,
        .ext_level, .pin_in);

    // Free-running system clock.
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task wait_cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_cyc

    // Cell clocks stay two system cycles in each phase, well under half rate.
    task pulse(input logic [3:0] b, input logic [3:0] r, input logic [3:0] g);
        blk_clk = b;
        regional_clk = r;
        global_clk = g;
        wait_cyc(2);
        blk_clk = '0;
        regional_clk = '0;
        global_clk = '0;
        wait_cyc(2);
    endtask : pulse

    task chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask : chk

    task finish_test;
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // A hang ends the run well past the roughly 75 cycles it needs.
    initial begin
        repeat (3000) @(posedge clk_sys);
        failures++;
        finish_test();
    end

    initial begin
        {reset_n, global_clk, regional_clk, cfg_ioe_src, dataout_a} = '0;
        {dataout_b, blk_oe, blk_ce_in, blk_ce_out, blk_clk, blk_aclr} = '0;
        {blk_sclr, cfg_invert, cfg_powerup_high, cfg_ddr_in} = '0;
        {cfg_ddr_out, cfg_oe_negedge, ext_drive, ext_level} = '0;
        cfg_row_block = 1'b1;
        cfg_route = '0;
        for (int i = 0; i < CELLS; i++) begin
            cfg_sel_oe[i] = 4'(i);
            cfg_sel_clk_out[i] = 4'(i);
            cfg_sel_clk_in[i] = 4'(i);
            cfg_sel_ce_in[i] = SEL_ONE;
            cfg_sel_ce_out[i] = SEL_ONE;
            cfg_sel_aclr[i] = SEL_ZERO;
            cfg_sel_sclr[i] = SEL_ZERO;
        end
        wait_cyc(10);
        reset_n = 1'b1;
        chk("pin_oe_n", 4'hf, pin_oe_n);
        chk("pin_out", 4'h0, pin_out);
        // Let the first edges after release pass before any cell clock moves.
        wait_cyc(2);
        // Plain output and enable, then per-cell inversion.
        dataout_a = 4'ha;
        blk_oe = 4'h5;
        pulse(4'hf, 4'h0, 4'h0);
        chk("pin_out", 4'ha, pin_out);
        chk("pin_oe_n", 4'ha, pin_oe_n);
        cfg_invert[1][INV_DATA_A] = 1'b1;
        cfg_invert[2][INV_OE] = 1'b1;
        pulse(4'hf, 4'h0, 4'h0);
        chk("pin_out", 4'h8, pin_out);
        chk("pin_oe_n", 4'he, pin_oe_n);
        cfg_invert = '0;
        // Clock enables picked per cell: constant off, lines, lines off.
        cfg_sel_ce_out = {4'h3, 4'h2, 4'h1, SEL_ZERO};
        blk_ce_out = 4'h6;
        dataout_a = 4'h5;
        blk_oe = 4'hf;
        pulse(4'hf, 4'h0, 4'h0);
        chk("pin_out", 4'hc, pin_out);
        chk("pin_oe_n", 4'h8, pin_oe_n);
        cfg_sel_ce_out = {4{SEL_ONE}};
        // Cell 3 output clocked from dedicated clock 2 off a regional clock.
        cfg_ioe_src[2] = 3'h5;
        cfg_sel_clk_out[3] = SEL_IOE_BASE + 4'h2;
        dataout_a = 4'h0;
        blk_oe = 4'h0;
        pulse(4'h0, 4'h2, 4'h0);
        chk("pin_out", 4'h4, pin_out);
        cfg_sel_clk_out[3] = 4'h3;
        // Synchronous clear loads the power-up level, but only on an edge.
        // The power-up level is static setup, so it changes only before a
        // clear or a reload of the output and enable registers; stored bits are kept relative to it.
        dataout_a = 4'hf;
        blk_oe = 4'hf;
        cfg_sel_sclr = {4{SEL_ONE}};
        wait_cyc(2);
        chk("pin_out", 4'h4, pin_out);
        pulse(4'hf, 4'h0, 4'h0);
        chk("pin_out", 4'h0, pin_out);
        chk("pin_oe_n", 4'hf, pin_oe_n);
        cfg_powerup_high = 4'h3;
        pulse(4'hf, 4'h0, 4'h0);
        chk("pin_out", 4'h3, pin_out);
        chk("pin_oe_n", 4'hc, pin_oe_n);
        cfg_sel_sclr = {4{SEL_ZERO}};
        cfg_powerup_high = 4'h0;
        dataout_a = 4'hf;
        blk_oe = 4'hf;
        pulse(4'hf, 4'h0, 4'h0);
        chk("pin_oe_n", 4'h0, pin_oe_n);
        // One clear source per cell, acting with no clock edge.
        cfg_sel_aclr = {SEL_ZERO, 4'h2, 4'h1, SEL_ONE};
        blk_aclr = 4'h4;
        #5;
        chk("pin_out", 4'ha, pin_out);
        chk("pin_oe_n", 4'h5, pin_oe_n);
        wait_cyc(1);
        cfg_sel_aclr = {4{SEL_ZERO}};
        blk_aclr = 4'h0;
        // Double rate output: A in the high phase, B in the low phase.
        cfg_ddr_out = 4'hf;
        dataout_a = 4'hc;
        dataout_b = 4'h3;
        blk_clk = 4'hf;
        wait_cyc(2);
        chk("pin_out", 4'hc, pin_out);
        blk_clk = 4'h0;
        wait_cyc(2);
        chk("pin_out", 4'h3, pin_out);
        // Falling-edge enable register holds the enable off for a half cycle.
        cfg_ddr_out = 4'h0;
        cfg_oe_negedge = 4'hf;
        blk_oe = 4'h0;
        pulse(4'hf, 4'h0, 4'h0);
        blk_oe = 4'hf;
        blk_clk = 4'hf;
        wait_cyc(2);
        chk("pin_oe_n", 4'hf, pin_oe_n);
        blk_clk = 4'h0;
        wait_cyc(2);
        chk("pin_oe_n", 4'h0, pin_oe_n);
        blk_oe = 4'h0;
        pulse(4'hf, 4'h0, 4'h0);
        cfg_oe_negedge = 4'h0;
        // Input capture on its own dedicated clock, routed per cell.
        ext_drive = 4'hf;
        ext_level = 4'hd;
        cfg_invert[1][INV_PIN] = 1'b1;
        cfg_sel_clk_in = {4{SEL_IOE_BASE}};
        cfg_route = {2'h2, ROUTE_LINK, ROUTE_ROW, ROUTE_COL};
        dataout_a = 4'h0;
        pulse(4'h0, 4'h0, 4'h1);
        chk("pin_out", 4'hc, pin_out);
        chk("col_data_a", 4'h1, col_data_a);
        chk("row_data_b", 4'h2, row_data_b);
        chk("link_data_a", 4'h4, link_data_a);
        chk("link_data_b", 4'h4, link_data_b);
        cfg_row_block = 1'b0;
        pulse(4'h0, 4'h0, 4'h1);
        chk("col_data_a", 4'hf, col_data_a);
        chk("row_data_a", 4'h0, row_data_a);
        // Double rate input: B from the fall, A from the following rise.
        cfg_ddr_in = 4'hf;
        global_clk = 4'h1;
        wait_cyc(2);
        ext_level = 4'h5;
        global_clk = 4'h0;
        wait_cyc(2);
        ext_level = 4'ha;
        global_clk = 4'h1;
        wait_cyc(2);
        ext_level = 4'h0;
        global_clk = 4'h0;
        wait_cyc(2);
        chk("col_data_a", 4'h8, col_data_a);
        chk("col_data_b", 4'h7, col_data_b);
        finish_test();
    end
endmodule : io_block_test
